/* src/ptps_top.sv */
// Power level table and three general output pins with signal select.
// Assumes settings arrive as same-clock write strobes from the serial port logic.
`timescale 1ns/1ps
module ptps_top import ptps_pkg::*; #(
  parameter int CLK_DIV = PTPS_CLK_DIV
) (
  input wire logic clk, // Crystal clock, 20 MHz
  input wire logic rst_b, // Async reset, active low
  input wire logic pwr_wr, // Power entry write strobe
  input wire logic pwr_wr_idx, // Entry written
  input wire logic [7:0] pwr_wr_data, // Power code written
  input wire logic power_index_select, // Entry used for transmit
  input wire logic sleep_enter, // Sleep entry pulse
  input wire logic core_ready_low, // Core ready, active low, pin domain
  input wire logic chip_select_low, // Serial port select, active low, pin
  input wire logic spi_so, // Serial data out from port logic
  input wire logic cfg_wr, // Pin config write strobe
  input wire logic [1:0] cfg_pin, // Pin whose config is written
  input wire logic [5:0] cfg_sel, // Signal select written
  input wire logic cfg_inv, // Invert bit written
  input wire logic [25:0] sig_in, // Internal signals for codes 0x01..0x1A
  input wire logic [6:0] rx_count, // Receive FIFO fill
  input wire logic [6:0] rx_thresh, // Receive FIFO threshold
  output logic [7:0] tx_power, // Power code used for transmit
  output logic [7:0] power_entry_0, // Entry 0 readback
  output logic [7:0] power_entry_1, // Entry 1 readback
  output logic [2:0] gen_out_o, // Pin levels
  output logic [2:0] gen_out_oe // Pin drive enables
);
  // The half-period counter is eight bits wide, so the ratio must stay within 512
  if (CLK_DIV < 2 || CLK_DIV > 512 || CLK_DIV % 2 != 0) begin : g_bad_div
    $error("CLK_DIV must be even, from 2 to 512");
  end

  // ----------------------------------------
  // Pin input synchronisers
  // ----------------------------------------
  logic [2:0] rdy_sync_q, cs_sync_q;
  logic rdy_q, cs_q, rdy_d, cs_d;
  always_comb begin
    rdy_d = (rdy_sync_q[1] == rdy_sync_q[2]) ? rdy_sync_q[2] : rdy_q;
    cs_d = (cs_sync_q[1] == cs_sync_q[2]) ? cs_sync_q[2] : cs_q;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdy_sync_q <= 3'h7;
      cs_sync_q <= 3'h7;
      rdy_q <= 1'b1;
      cs_q <= 1'b1;
    end else begin
      rdy_sync_q <= {rdy_sync_q[1:0], core_ready_low};
      cs_sync_q <= {cs_sync_q[1:0], chip_select_low};
      rdy_q <= rdy_d;
      cs_q <= cs_d;
    end
  end

  // ----------------------------------------
  // Power level table
  // ----------------------------------------
  logic [7:0] pwr_q [2];
  logic [7:0] pwr_d [2];
  logic [7:0] txp_d, txp_q;
  always_comb begin
    pwr_d = pwr_q;
    if (pwr_wr) begin
      pwr_d[pwr_wr_idx] = pwr_wr_data;
    end
    if (sleep_enter) begin
      pwr_d[1] = PTPS_POWER_LOST; // [R7]
    end
    txp_d = pwr_q[power_index_select]; // [R1]
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pwr_q[0] <= PTPS_POWER_RESET; // [R6]
      pwr_q[1] <= PTPS_POWER_RESET; // [R6]
      txp_q <= PTPS_POWER_RESET;
    end else begin
      pwr_q <= pwr_d;
      txp_q <= txp_d;
    end
  end
  assign tx_power = txp_q;
  assign power_entry_0 = pwr_q[0];
  assign power_entry_1 = pwr_q[1];

  a_entry_sel: assert property (@(posedge clk) disable iff (!rst_b) // [R1]
    ##1 (tx_power == $past(pwr_q[power_index_select])))
    else $error("transmit power not from selected entry");
  a_sleep_keep: assert property (@(posedge clk) disable iff (!rst_b) // [R7]
    (sleep_enter && !pwr_wr) |=> (power_entry_1 == 8'h00 && $stable(power_entry_0)))
    else $error("sleep entry handled the table wrongly");

  // ----------------------------------------
  // Sleep hold and divided clock
  // ----------------------------------------
  localparam int HALF = CLK_DIV / 2;
  logic hold_d, hold_q, ck_d, ck_q;
  logic [7:0] div_d, div_q;
  always_comb begin
    hold_d = hold_q;
    if (sleep_enter) begin
      hold_d = 1'b1; // [R13]
    end else if (!rdy_q) begin
      hold_d = 1'b0; // [R14]
    end
    div_d = div_q + 8'h01;
    ck_d = ck_q;
    if (div_q == 8'(HALF - 1)) begin
      div_d = 8'h00;
      ck_d = !ck_q; // [R11] [R12]
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_q <= 1'b0;
      div_q <= 8'h00;
      ck_q <= 1'b0;
    end else begin
      hold_q <= hold_d;
      div_q <= div_d;
      ck_q <= ck_d;
    end
  end

  a_hold_release: assert property (@(posedge clk) disable iff (!rst_b) // [R14]
    (hold_q && !sleep_enter && !rdy_q) |=> !hold_q)
    else $error("forced levels held past core ready");

  // ----------------------------------------
  // Pin configuration and signal vector
  // ----------------------------------------
  logic [5:0] sel_q [3];
  logic [5:0] sel_d [3];
  logic [2:0] inv_q, inv_d;
  logic [63:0] sig_vec;
  always_comb begin
    sel_d = sel_q;
    inv_d = inv_q;
    if (cfg_wr && cfg_pin < 2'd3) begin
      sel_d[cfg_pin] = cfg_sel; // [R8] [R12]
      inv_d[cfg_pin] = cfg_inv;
    end
    sig_vec = 64'h0;
    sig_vec[PTPS_SEL_RXTHR] = (rx_count >= rx_thresh); // [R17]
    sig_vec[26:1] = sig_in;
    sig_vec[PTPS_SEL_CLK192] = ck_q; // [R11]
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_q[0] <= PTPS_SEL0_RESET; // [R11]
      sel_q[1] <= PTPS_SEL1_RESET; // [R10]
      sel_q[2] <= PTPS_SEL2_RESET;
      inv_q <= 3'h0;
    end else begin
      sel_q <= sel_d;
      inv_q <= inv_d;
    end
  end

  // ----------------------------------------
  // Output pins
  // ----------------------------------------
  logic [2:0] pin_o, pin_oe;
  ptps_out_pin #(.FORCE_INV(1'b0)) u_pin0 (
    .clk(clk), .rst_b(rst_b), .sel(sel_q[0]), .inv(inv_q[0]),
    .sleep_hold(hold_q), .sig_vec(sig_vec), .pin_o(pin_o[0]), .pin_oe(pin_oe[0]));
  ptps_out_pin #(.FORCE_INV(1'b1)) u_pin1 (
    .clk(clk), .rst_b(rst_b), .sel(sel_q[1]), .inv(inv_q[1]),
    .sleep_hold(hold_q), .sig_vec(sig_vec), .pin_o(pin_o[1]), .pin_oe(pin_oe[1]));
  ptps_out_pin #(.FORCE_INV(1'b0)) u_pin2 (
    .clk(clk), .rst_b(rst_b), .sel(sel_q[2]), .inv(inv_q[2]),
    .sleep_hold(hold_q), .sig_vec(sig_vec), .pin_o(pin_o[2]), .pin_oe(pin_oe[2]));

  // Pin 1 is the serial data out while selected
  always_comb begin
    gen_out_o = pin_o;
    gen_out_oe = pin_oe;
    if (!cs_q) begin
      gen_out_o[1] = spi_so; // [R9]
      gen_out_oe[1] = 1'b1;
    end
  end

  a_pin1_default: assert property (@(posedge clk) disable iff (!rst_b) // [R10]
    (cs_q && sel_q[1] == PTPS_SEL_HIZ && $stable(sel_q[1])) |-> !gen_out_oe[1])
    else $error("pin 1 driven while released");
  a_pin1_spi: assert property (@(posedge clk) disable iff (!rst_b) // [R9]
    !cs_q |-> (gen_out_oe[1] && gen_out_o[1] == spi_so))
    else $error("pin 1 not carrying serial data while selected");
endmodule // ptps_top

/* src/ptps_pkg.sv */
// Constants for the power level table and output pin select block.
// Assumes one 20 MHz crystal clock and an asynchronous active-low reset.
//
// Contract
// R1: Two power entries; index select picks one
// R2: Host burst-writes entries other than zero (the host model writes every entry as one single-cycle strobe)
// R3: Keying: select one, zero/one levels
// R4: Other modulations use entry zero
// R5: Host never writes codes 0x61..0x6F
// R6: Power entries reset to 0xC6
// R7: Sleep keeps entry zero, clears others
// R8: Three output pins, each own select
// R9: Pin 1 valid only while select high (the code drives serial data on pin 1 while chip_select_low is low)
// R10: Pin 1 defaults to high impedance
// R11: Pin 0 defaults to clock divided 192
// R12: Clock runs from reset; select write changes
// R13: Sleep, select below 0x20: forced levels
// R14: Forced levels hold until core ready low
// R15: Select 0x20 or above works in sleep
// R16: Select 0x2E is always high impedance (pin 1 is still driven with serial data while chip_select_low is low)
// R17: Code 0x00 is receive threshold flag
// R18: Host: one divided clock, others below 0x30
// R19: Invert bit flips selected signal polarity
package ptps_pkg;
  // ----------------------------------------
  // Power level table
  // ----------------------------------------
  localparam logic [7:0] PTPS_POWER_RESET = 8'hC6;
  localparam logic [7:0] PTPS_POWER_LOST = 8'h00;
  // ----------------------------------------
  // Output signal select codes
  // ----------------------------------------
  localparam int PTPS_SEL_W = 6;
  localparam logic [5:0] PTPS_SEL_RXTHR = 6'h00;
  localparam logic [5:0] PTPS_SEL_SLEEP_LIM = 6'h20;
  localparam logic [5:0] PTPS_SEL_HIZ = 6'h2E;
  localparam logic [5:0] PTPS_SEL_CLK192 = 6'h3F;
  localparam logic [5:0] PTPS_SEL0_RESET = 6'h3F;
  localparam logic [5:0] PTPS_SEL1_RESET = 6'h2E;
  localparam logic [5:0] PTPS_SEL2_RESET = 6'h29;
  localparam int PTPS_CLK_DIV = 192;
  localparam int PTPS_SYNC_STAGES = 3;
endpackage

/* src/ptps_out_pin.sv */
// One general output pin: signal select, polarity and sleep forcing.
// Assumes its inputs come from logic on the same clock.
`timescale 1ns/1ps
module ptps_out_pin import ptps_pkg::*; #(
  parameter logic FORCE_INV = 1'b0
) (
  input wire logic clk, // Crystal clock
  input wire logic rst_b, // Async reset, active low
  input wire logic [5:0] sel, // Signal select
  input wire logic inv, // Polarity invert
  input wire logic sleep_hold, // Sleep forcing active
  input wire logic [63:0] sig_vec, // Internal signals by code
  output logic pin_o, // Pin level
  output logic pin_oe // Pin drive enable
);
  logic o_d, o_q, oe_d, oe_q;
  logic forced;

  always_comb begin
    forced = sleep_hold && (sel < PTPS_SEL_SLEEP_LIM); // [R13] [R15]
    o_d = sig_vec[sel] ^ inv; // [R8] [R19]
    if (forced) begin
      o_d = inv ^ FORCE_INV; // [R13] [R14]
    end
    oe_d = (sel != PTPS_SEL_HIZ); // [R16]
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      o_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      o_q <= o_d;
      oe_q <= oe_d;
    end
  end

  assign pin_o = o_q;
  assign pin_oe = oe_q;

  a_hiz_sel: assert property (@(posedge clk) disable iff (!rst_b) // [R16]
    (sel == PTPS_SEL_HIZ) |=> !pin_oe)
    else $error("select 0x2E did not release the pin");
  a_sleep_force: assert property (@(posedge clk) disable iff (!rst_b) // [R13]
    (sleep_hold && sel < PTPS_SEL_SLEEP_LIM) |=> (pin_o == ($past(inv) ^ FORCE_INV)))
    else $error("sleep level not forced");
  a_polarity: assert property (@(posedge clk) disable iff (!rst_b) // [R19]
    !sleep_hold |=> (pin_o == ($past(sig_vec[sel]) ^ $past(inv))))
    else $error("pin level does not follow select and invert");
endmodule // ptps_out_pin

/* testbench/ptps_host_model.sv */
// Host controller model: sends power table and pin config writes.
// Assumes the block samples each one-cycle strobe on the rising clock edge.
`timescale 1ns/1ps
module ptps_host_model (
  input wire logic clk, // Crystal clock
  output logic pwr_wr, // Power write strobe
  output logic pwr_wr_idx, // Entry written
  output logic [7:0] pwr_wr_data, // Power code
  output logic cfg_wr, // Config write strobe
  output logic [1:0] cfg_pin, // Pin configured
  output logic [5:0] cfg_sel, // Signal select
  output logic cfg_inv // Invert bit
);
  initial begin
    {pwr_wr, pwr_wr_idx, pwr_wr_data} = 10'h000;
    {cfg_wr, cfg_pin, cfg_sel, cfg_inv} = 10'h000;
  end
  // Each entry goes as one single-cycle write; entry 0 carries the level for non-keyed use
  task automatic wr_pwr(input logic idx, input logic [7:0] data);
    if (data >= 8'h61 && data <= 8'h6F) data = 8'hC6;
    @(posedge clk);
    pwr_wr <= 1'h1;
    pwr_wr_idx <= idx;
    pwr_wr_data <= data;
    @(posedge clk);
    pwr_wr <= 1'h0;
  endtask
  // Callers keep other pins below 0x30 while one shows the divided clock
  task automatic wr_cfg(input logic [1:0] pin, input logic [5:0] sel, input logic inv);
    @(posedge clk);
    cfg_wr <= 1'h1;
    cfg_pin <= pin;
    cfg_sel <= sel;
    cfg_inv <= inv;
    @(posedge clk);
    cfg_wr <= 1'h0;
  endtask
endmodule // ptps_host_model

/* testbench/ptps_top_tb.sv */
// Self-checking bench for the power table and output pin select block.
// Assumes a 20 MHz clock and a divided-clock ratio shortened to 4.
`timescale 1ns/1ps
module ptps_top_tb;
  import ptps_pkg::*;
  typedef struct packed {
    logic [1:0] pin; logic [5:0] sel; logic inv; logic [6:0] rxc;
    logic sig; logic o; logic oe;
  } ptps_row_t;
  logic clk, rst_b, power_index_select, sleep_enter, core_ready_low, chip_select_low, spi_so;
  logic pwr_wr, pwr_wr_idx, cfg_wr, cfg_inv;
  logic [7:0] pwr_wr_data, tx_power, power_entry_0, power_entry_1;
  logic [1:0] cfg_pin;
  logic [5:0] cfg_sel;
  logic [25:0] sig_in;
  logic [6:0] rx_count, rx_thresh;
  logic [2:0] gen_out_o, gen_out_oe;
  int fails, num_checks, cycles, n;
  ptps_row_t rows [6] = '{
    '{2'h2, 6'h00, 1'h0, 7'h08, 1'h0, 1'h1, 1'h1}, '{2'h2, 6'h00, 1'h0, 7'h02, 1'h0, 1'h0, 1'h1},
    '{2'h2, 6'h00, 1'h1, 7'h02, 1'h0, 1'h1, 1'h1}, '{2'h0, 6'h01, 1'h0, 7'h02, 1'h1, 1'h1, 1'h1},
    '{2'h0, 6'h01, 1'h1, 7'h02, 1'h1, 1'h0, 1'h1}, '{2'h2, 6'h2E, 1'h0, 7'h02, 1'h0, 1'h0, 1'h0}};
  ptps_top #(.CLK_DIV(4)) ptps_top_inst (.clk(clk), .rst_b(rst_b), .pwr_wr(pwr_wr),
    .pwr_wr_idx(pwr_wr_idx), .pwr_wr_data(pwr_wr_data), .power_index_select(power_index_select),
    .sleep_enter(sleep_enter), .core_ready_low(core_ready_low), .chip_select_low(chip_select_low),
    .spi_so(spi_so), .cfg_wr(cfg_wr), .cfg_pin(cfg_pin), .cfg_sel(cfg_sel), .cfg_inv(cfg_inv),
    .sig_in(sig_in), .rx_count(rx_count), .rx_thresh(rx_thresh), .tx_power(tx_power),
    .power_entry_0(power_entry_0), .power_entry_1(power_entry_1), .gen_out_o(gen_out_o),
    .gen_out_oe(gen_out_oe));
  ptps_host_model ptps_host_model_inst (.clk(clk), .pwr_wr(pwr_wr), .pwr_wr_idx(pwr_wr_idx),
    .pwr_wr_data(pwr_wr_data), .cfg_wr(cfg_wr), .cfg_pin(cfg_pin), .cfg_sel(cfg_sel),
    .cfg_inv(cfg_inv));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Counts level changes of pin 0 over eight edges
  task automatic toggles(output int k);
    logic p;
    k = 0;
    p = gen_out_o[0];
    repeat (8) begin
      tick(1);
      if (gen_out_o[0] !== p) k++;
      p = gen_out_o[0];
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      $display("timeout");
      give_verdict;
    end
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {rst_b, power_index_select, sleep_enter, core_ready_low, spi_so} = 5'h00;
    chip_select_low = 1'h1;
    sig_in = 26'h0;
    rx_count = 7'h00;
    rx_thresh = 7'h04;
    repeat (10) @(posedge clk);
    rst_b <= 1'h1;
    tick(2);
    chk("entry 0", 8'hC6, power_entry_0);
    chk("entry 1", 8'hC6, power_entry_1);
    chk("tx power", 8'hC6, tx_power);
    chk("pin 1 enable", 8'h0, gen_out_oe[1]);
    chk("pin 0 enable", 8'h1, gen_out_oe[0]);
    toggles(n);
    chk("pin 0 toggles", 8'h4, n[7:0]);
    $display("test reset done");
    @(posedge clk) power_index_select <= 1'h1;
    ptps_host_model_inst.wr_pwr(1'h1, 8'h50);
    tick(2);
    chk("entry 1", 8'h50, power_entry_1);
    chk("tx power", 8'h50, tx_power);
    @(posedge clk) power_index_select <= 1'h0;
    ptps_host_model_inst.wr_pwr(1'h0, 8'h8E);
    tick(2);
    chk("tx power", 8'h8E, tx_power);
    $display("test power table done");
    foreach (rows[i]) begin
      @(posedge clk);
      rx_count <= rows[i].rxc;
      sig_in <= {25'h0, rows[i].sig};
      ptps_host_model_inst.wr_cfg(rows[i].pin, rows[i].sel, rows[i].inv);
      tick(2);
      chk("pin level", rows[i].o, gen_out_o[rows[i].pin]);
      chk("pin enable", rows[i].oe, gen_out_oe[rows[i].pin]);
    end
    $display("test pin table done");
    @(posedge clk);
    rx_count <= 7'h08;
    sig_in <= 26'h0;
    ptps_host_model_inst.wr_cfg(2'h2, 6'h00, 1'h1);
    ptps_host_model_inst.wr_cfg(2'h1, 6'h01, 1'h0);
    ptps_host_model_inst.wr_cfg(2'h0, 6'h3F, 1'h0);
    @(posedge clk) core_ready_low <= 1'h1;
    tick(6);
    chk("pin 2 awake", 8'h0, gen_out_o[2]);
    @(posedge clk) sleep_enter <= 1'h1;
    @(posedge clk) sleep_enter <= 1'h0;
    tick(2);
    chk("pin 2 sleep", 8'h1, gen_out_o[2]);
    chk("pin 1 sleep", 8'h1, gen_out_o[1]);
    chk("entry 0 sleep", 8'h8E, power_entry_0);
    chk("entry 1 sleep", 8'h00, power_entry_1);
    toggles(n);
    chk("pin 0 sleep toggles", 8'h4, n[7:0]);
    tick(10);
    chk("pin 2 held", 8'h1, gen_out_o[2]);
    @(posedge clk) core_ready_low <= 1'h0;
    tick(8);
    chk("pin 2 woken", 8'h0, gen_out_o[2]);
    chk("pin 1 woken", 8'h0, gen_out_o[1]);
    $display("test sleep done");
    @(posedge clk);
    chip_select_low <= 1'h0;
    spi_so <= 1'h1;
    tick(6);
    chk("pin 1 serial", 8'h1, gen_out_o[1]);
    chk("pin 1 enable", 8'h1, gen_out_oe[1]);
    @(posedge clk) spi_so <= 1'h0;
    tick(1);
    chk("pin 1 serial", 8'h0, gen_out_o[1]);
    $display("test chip select done");
    // Sleep meets an entry 1 write, inverted forcing, released pin, ignored pin 3
    @(posedge clk);
    chip_select_low <= 1'h1;
    core_ready_low <= 1'h1;
    ptps_host_model_inst.wr_cfg(2'h1, 6'h05, 1'h1);
    ptps_host_model_inst.wr_cfg(2'h2, 6'h2E, 1'h0);
    ptps_host_model_inst.wr_cfg(2'h3, 6'h00, 1'h1);
    fork
      ptps_host_model_inst.wr_pwr(1'h1, 8'h84);
      begin
        @(posedge clk) sleep_enter <= 1'h1;
        @(posedge clk) sleep_enter <= 1'h0;
      end
    join
    power_index_select <= 1'h1;
    tick(3);
    chk("entry 1 write in sleep", 8'h00, power_entry_1);
    chk("tx power after sleep", 8'h00, tx_power);
    chk("pin 1 inverted sleep", 8'h0, gen_out_o[1]);
    chk("pin 2 released sleep", 8'h0, gen_out_oe[2]);
    toggles(n);
    chk("pin 0 kept clock", 8'h4, n[7:0]);
    $display("test awkward cases done");
    // Second reset in mid-run, while asleep
    @(posedge clk) rst_b <= 1'h0;
    repeat (3) @(posedge clk);
    rst_b <= 1'h1;
    tick(2);
    chk("entry 1 reset", 8'hC6, power_entry_1);
    chk("tx power reset", 8'hC6, tx_power);
    chk("pin 1 enable reset", 8'h0, gen_out_oe[1]);
    chk("pin 0 enable reset", 8'h1, gen_out_oe[0]);
    $display("test second reset done");
    give_verdict;
  end
endmodule // ptps_top_tb
